// ### verilog/tristate_remote_encoder.sv
// tri-state remote encoder: samples inputs, sends three-word packet cycles
`timescale 1ns/100ps
`default_nettype none
module tristate_remote_encoder #(
    parameter int LAG_CLKS = encoder_pkg::LAG_CLKS,
    parameter int CHIP_DIV = encoder_pkg::CHIP_DIV
) (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       send_request_i,
    input  wire logic [9:0] address_code_inputs_i,
    input  wire logic [9:0] address_code_float_i,
    input  wire logic [7:0] payload_inputs_i,
    input  wire logic [7:0] payload_float_i,
    output logic            serial_tx_o,
    output logic            busy_o
);
    localparam int SW = 1 + 2 * encoder_pkg::SYMS;

    // ==========================================================
    // input synchronisers
    logic [SW-1:0] meta_reg;
    logic [SW-1:0] sync_reg;
    logic          req_prev_reg;
    logic          req_s;
    logic [17:0]   level_s;
    logic [17:0]   float_s;
    logic          req_rise;

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg     <= '0;
            sync_reg     <= '0;
            req_prev_reg <= 1'b0;
        end else begin
            meta_reg     <= {send_request_i, payload_float_i, address_code_float_i,
                             payload_inputs_i, address_code_inputs_i};
            sync_reg     <= meta_reg;
            req_prev_reg <= sync_reg[SW-1];
        end
    end

    assign req_s    = sync_reg[SW-1];
    assign level_s  = sync_reg[17:0];
    assign float_s  = sync_reg[35:18];
    assign req_rise = req_s && !req_prev_reg;

    // ==========================================================
    // chip rate divider
    logic [encoder_pkg::DIV_W-1:0] div_reg;
    logic                          chip_tick;

    // one-cycle enable at the encoder oscillator rate
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_reg <= '0;
        end else if (div_reg == encoder_pkg::DIV_W'(CHIP_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign chip_tick = (div_reg == encoder_pkg::DIV_W'(CHIP_DIV - 1));

    // ==========================================================
    // packet sequencer
    encoder_pkg::enc_state_e state_reg;
    logic [4:0]              sym_reg;
    logic [3:0]              chip_reg;
    logic [1:0]              word_reg;
    logic [17:0]             level_reg;
    logic [17:0]             float_reg;
    logic                    buf_in_ready;
    logic                    push;
    logic                    sym_end;
    logic                    word_end;
    logic                    cycle_end;
    logic                    chip_val;
    logic                    half_hi;
    logic [1:0]              pos;
    logic                    half_val;

    assign push      = (state_reg != encoder_pkg::ST_IDLE) && buf_in_ready;
    assign sym_end   = (chip_reg == 4'(encoder_pkg::SYM_CHIPS - 1));
    assign word_end  = push && (state_reg == encoder_pkg::ST_SYNC)
                       && (chip_reg == 4'(encoder_pkg::SYNC_CHIPS - 1));
    assign cycle_end = word_end && (word_reg == 2'(encoder_pkg::WORDS - 1));

    // state, counters; a dropped request only matters at cycle end
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= encoder_pkg::ST_IDLE;
            sym_reg   <= 5'h0;
            chip_reg  <= 4'h0;
            word_reg  <= 2'h0;
        end else begin
            case (state_reg)
                encoder_pkg::ST_IDLE: begin
                    if (req_rise) begin
                        state_reg <= encoder_pkg::ST_DATA;
                        sym_reg   <= 5'h0;
                        chip_reg  <= 4'h0;
                        word_reg  <= 2'h0;
                    end
                end
                encoder_pkg::ST_DATA: begin
                    if (push) begin
                        chip_reg <= sym_end ? 4'h0 : chip_reg + 4'h1;
                        if (sym_end) begin
                            if (sym_reg == 5'(encoder_pkg::SYMS - 1)) begin
                                state_reg <= encoder_pkg::ST_SYNC;
                                sym_reg   <= 5'h0;
                            end else begin
                                sym_reg <= sym_reg + 5'h1;
                            end
                        end
                    end
                end
                encoder_pkg::ST_SYNC: begin
                    if (push) begin
                        chip_reg <= word_end ? 4'h0 : chip_reg + 4'h1;
                        if (cycle_end) begin
                            word_reg  <= 2'h0;
                            state_reg <= req_s ? encoder_pkg::ST_DATA
                                               : encoder_pkg::ST_IDLE;
                        end else if (word_end) begin
                            word_reg  <= word_reg + 2'h1;
                            state_reg <= encoder_pkg::ST_DATA;
                        end
                    end
                end
                default: begin
                    state_reg <= encoder_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // snapshot at activation and again at every new cycle
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_reg <= 18'h0_0000;
            float_reg <= 18'h0_0000;
        end else if ((state_reg == encoder_pkg::ST_IDLE && req_rise)
                     || (cycle_end && req_s)) begin
            level_reg <= level_s;
            float_reg <= float_s;
        end
    end

    // chip pattern: each half is 1,v,0; low=00, high=11, float=01
    always_comb begin
        half_hi  = (chip_reg >= 4'(encoder_pkg::HALF_CHIPS));
        pos      = half_hi ? 2'(chip_reg - 4'(encoder_pkg::HALF_CHIPS)) : 2'(chip_reg);
        half_val = float_reg[sym_reg] ? half_hi : level_reg[sym_reg];
        if (state_reg == encoder_pkg::ST_SYNC) begin
            chip_val = (chip_reg == 4'h0);
        end else if (pos == 2'h0) begin
            chip_val = 1'b1;
        end else if (pos == 2'h1) begin
            chip_val = half_val;
        end else begin
            chip_val = 1'b0;
        end
    end

    // ==========================================================
    // chip buffer and serial output
    logic buf_out_valid;
    logic buf_out_data;
    logic tx_reg;

    chip_buffer #(
        .W (1)
    ) u_chip_buffer (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (state_reg != encoder_pkg::ST_IDLE),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (chip_val),
        .out_valid_o (buf_out_valid),
        .out_ready_i (chip_tick),
        .out_data_o  (buf_out_data)
    );

    // one chip per tick onto the modulator line, low when nothing is queued
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_reg <= 1'b0;
        end else if (chip_tick) begin
            tx_reg <= buf_out_valid ? buf_out_data : 1'b0;
        end
    end

    assign serial_tx_o = tx_reg;
    assign busy_o      = (state_reg != encoder_pkg::ST_IDLE) || buf_out_valid;

    // ==========================================================
    // checks
    logic [24:0] cyc_cnt_reg;

    // clocks since the current cycle began
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_cnt_reg <= 25'h000_0000;
        end else if (state_reg == encoder_pkg::ST_IDLE || cycle_end) begin
            cyc_cnt_reg <= 25'h000_0000;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 25'h1;
        end
    end

    a_start_on_rise: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_reg == encoder_pkg::ST_IDLE && req_rise) |=> state_reg == encoder_pkg::ST_DATA)
        else $error("rising request did not start a transmission");
    a_capture_inputs: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_reg == encoder_pkg::ST_IDLE && req_rise)
        |=> level_reg == $past(level_s) && float_reg == $past(float_s))
        else $error("inputs not captured on activation");
    a_three_words: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        word_end |-> word_reg <= 2'(encoder_pkg::WORDS - 1))
        else $error("more than three words in one cycle");
    a_repeat_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (cycle_end && req_s) |=> state_reg == encoder_pkg::ST_DATA && word_reg == 2'h0)
        else $error("cycle not repeated while request held");
    a_finish_cycle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_reg != encoder_pkg::ST_IDLE && !cycle_end) |=> state_reg != encoder_pkg::ST_IDLE)
        else $error("cycle aborted before its end");
    a_symbol_order: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (push && state_reg == encoder_pkg::ST_DATA && sym_end
         && sym_reg != 5'(encoder_pkg::SYMS - 1))
        |=> sym_reg == $past(sym_reg) + 5'h1)
        else $error("symbols left out of order");
    a_float_pattern: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (state_reg == encoder_pkg::ST_DATA && float_reg[sym_reg] && chip_reg == 4'h1)
        |-> !chip_val)
        else $error("floating symbol first half not low");
    a_serial_out: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (chip_tick && buf_out_valid) |=> serial_tx_o == $past(buf_out_data))
        else $error("queued chip not driven on the serial line");
    a_idle_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (chip_tick && !buf_out_valid) |=> !serial_tx_o)
        else $error("serial line not low while idle");
    a_resample: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (cycle_end && req_s) |=> level_reg == $past(level_s))
        else $error("inputs not sampled again at a new cycle");
    a_lag_bound: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cyc_cnt_reg < 25'(LAG_CLKS))
        else $error("cycle longer than the allowed input lag");

    c_start: cover property (@(posedge clock_i) disable iff (sys_rst_i) req_rise);
    c_repeat: cover property (@(posedge clock_i) disable iff (sys_rst_i) cycle_end && req_s);
    c_stop: cover property (@(posedge clock_i) disable iff (sys_rst_i) cycle_end && !req_s);
    c_stall: cover property (@(posedge clock_i) disable iff (sys_rst_i) !buf_in_ready);
endmodule : tristate_remote_encoder
`default_nettype wire

// ### verilog/encoder_pkg.sv
// constants for the tri-state remote encoder
package encoder_pkg;
    // clock and chip timing
    localparam int CLK_HZ      = 125_000_000;
    localparam int OSC_HZ      = 70_000;
    localparam int CHIP_DIV    = CLK_HZ / OSC_HZ;
    localparam int DIV_W       = 11;
    // worst lag from an input change to its appearance on air
    localparam int LAG_MS      = 150;
    localparam int LAG_CLKS    = LAG_MS * (CLK_HZ / 1000);
    // packet layout
    localparam int ADDR_BITS   = 10;
    localparam int DATA_BITS   = 8;
    localparam int SYMS        = ADDR_BITS + DATA_BITS;
    localparam int WORDS       = 3;
    localparam int HALF_CHIPS  = 3;
    localparam int SYM_CHIPS   = 2 * HALF_CHIPS;
    localparam int SYNC_CHIPS  = 12;
    localparam int WORD_CHIPS  = SYMS * SYM_CHIPS + SYNC_CHIPS;
    localparam int CYCLE_CHIPS = WORDS * WORD_CHIPS;
    localparam int BUF_DEPTH   = 2;
    // encoder states, gray along idle -> data -> sync
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_SYNC = 2'b11
    } enc_state_e;
endpackage : encoder_pkg

// ### verilog/chip_buffer.sv
// two-entry valid/ready buffer for serial chips
`timescale 1ns/100ps
`default_nettype none
module chip_buffer #(
    parameter int W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    logic [W-1:0] mem_reg [encoder_pkg::BUF_DEPTH];
    logic         wr_ptr_reg;
    logic         rd_ptr_reg;
    logic [1:0]   count_reg;
    logic         push;
    logic         pop;

    // honest full and empty from the entry count
    assign in_ready_o  = (count_reg != 2'(encoder_pkg::BUF_DEPTH));
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage written at the write index
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + 2'(push) - 2'(pop);
        end
    end
endmodule : chip_buffer
`default_nettype wire

// ### tb/remote_decoder_model.sv
// decoder model: recovers tri-state symbols from the chip stream and checks the address
`timescale 1ns/100ps
`default_nettype none
module remote_decoder_model #(
    parameter int DIV = encoder_pkg::CHIP_DIV
) (
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       serial_rx_i,
    input  wire logic [9:0] local_level_i,
    input  wire logic [9:0] local_float_i,
    output logic            word_strobe_o,
    output logic [35:0]     symbols_o,
    output logic            match_o,
    output logic [7:0]      payload_out_o
);
    // ====
    // chip sampling and word decode
    localparam int NCH = encoder_pkg::WORD_CHIPS;
    logic [NCH-1:0] chips_reg;
    logic           active_reg;
    logic           prev_reg;
    logic           decode_reg;
    int             phase_reg;
    int             count_reg;

    // chips are stored first in time at the lsb; anything else decodes as bad
    function automatic logic [1:0] sym_of(input logic [5:0] c);
        case (c)
            6'h09:   return 2'b00;
            6'h1b:   return 2'b01;
            6'h19:   return 2'b10;
            default: return 2'b11;
        endcase
    endfunction : sym_of

    // find a word start, sample each chip mid-way, decode after the last chip
    always @(posedge clock_i or posedge sys_rst_i) begin : decode_p
        logic [35:0] sy;
        logic [1:0]  ls;
        logic        hit;
        if (sys_rst_i) begin
            active_reg    <= 1'b0;
            prev_reg      <= 1'b0;
            decode_reg    <= 1'b0;
            phase_reg     <= 0;
            count_reg     <= 0;
            word_strobe_o <= 1'b0;
            symbols_o     <= '0;
            match_o       <= 1'b0;
            payload_out_o <= '0;
        end else begin
            word_strobe_o <= 1'b0;
            prev_reg      <= serial_rx_i;
            phase_reg     <= (phase_reg == DIV - 1) ? 0 : phase_reg + 1;
            if (!active_reg && serial_rx_i && !prev_reg) begin
                active_reg <= 1'b1;
                phase_reg  <= 1;
                count_reg  <= 0;
            end
            if (active_reg && phase_reg == DIV / 2) begin
                chips_reg[count_reg] <= serial_rx_i;
                count_reg            <= count_reg + 1;
                active_reg           <= (count_reg != NCH - 1);
                decode_reg           <= (count_reg == NCH - 1);
            end
            if (decode_reg) begin
                decode_reg <= 1'b0;
                hit = (chips_reg[NCH-1:NCH-12] == 12'h001);
                for (int k = 0; k < 18; k++) begin
                    sy[2*k +: 2] = sym_of(chips_reg[6*k +: 6]);
                    hit = hit && (sy[2*k +: 2] != 2'b11);
                end
                for (int k = 0; k < 10; k++) begin
                    ls = local_float_i[k] ? 2'b10 : {1'b0, local_level_i[k]};
                    hit = hit && (sy[2*k +: 2] == ls);
                end
                for (int k = 0; k < 8; k++) begin
                    if (hit) payload_out_o[k] <= (sy[20+2*k +: 2] == 2'b01);
                end
                symbols_o     <= sy;
                match_o       <= hit;
                word_strobe_o <= 1'b1;
            end
        end
    end
endmodule : remote_decoder_model
`default_nettype wire

// ### tb/testbench.sv
// testbench: random tri-state codes sent through the encoder to a decoder model
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ====
    // signals
    // short chip period so that whole packet cycles fit in a brief run
    localparam int DIV = 20;
    localparam int GAP = encoder_pkg::WORD_CHIPS * DIV;
    logic        clock_i;
    logic        sys_rst_i;
    logic        send_request_i;
    logic [9:0]  addr_level, addr_float, local_level, local_float, al, af;
    logic [7:0]  pay_level, pay_float, dl, df, pay_a;
    logic        serial_tx_o;
    logic        busy_o;
    logic        word_strobe;
    logic        match;
    logic [35:0] symbols, exp_w;
    logic [7:0]  payload_out;
    int          fail_count, comparisons, cyc, last_t;

    tristate_remote_encoder #(
        .LAG_CLKS(encoder_pkg::CYCLE_CHIPS * DIV + 100),
        .CHIP_DIV(DIV)
    ) tristate_remote_encoder_i (
        .clock_i              (clock_i),
        .sys_rst_i            (sys_rst_i),
        .send_request_i       (send_request_i),
        .address_code_inputs_i(addr_level),
        .address_code_float_i (addr_float),
        .payload_inputs_i     (pay_level),
        .payload_float_i      (pay_float),
        .serial_tx_o          (serial_tx_o),
        .busy_o               (busy_o)
    );

    remote_decoder_model #(
        .DIV(DIV)
    ) remote_decoder_model_i (
        .clock_i      (clock_i),
        .sys_rst_i    (sys_rst_i),
        .serial_rx_i  (serial_tx_o),
        .local_level_i(local_level),
        .local_float_i(local_float),
        .word_strobe_o(word_strobe),
        .symbols_o    (symbols),
        .match_o      (match),
        .payload_out_o(payload_out)
    );

    // free-running clock and edge count for word spacing
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) cyc <= cyc + 1;

    // ====
    // helpers
    function automatic logic [35:0] expect_word(input logic [17:0] f, input logic [17:0] l);
        logic [35:0] w;
        for (int k = 0; k < 18; k++) w[2*k +: 2] = f[k] ? 2'b10 : {1'b0, l[k]};
        return w;
    endfunction : expect_word

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic check_vec(input string name, input logic [35:0] e, input logic [35:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask : check_vec

    task automatic check_gap(input string name, input int e, input int g);
        comparisons++;
        if (g != e) begin
            fail_count++;
            $display("unexpected %s expected %0d seen %0d", name, e, g);
        end
    endtask : check_gap

    task automatic drive;
        @(posedge clock_i);
        addr_level <= al;
        addr_float <= af;
        pay_level  <= dl;
        pay_float  <= df;
    endtask : drive

    task automatic take_word(input logic [35:0] e, input bit spaced);
        int n;
        n = 0;
        while (word_strobe !== 1'b1 && n < 2 * GAP) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 2 * GAP) begin
            fail_count++;
            $display("unexpected timeout waiting for a word");
            summarize();
        end else begin
            check_vec("word symbols", e, symbols);
            if (spaced) check_gap("word spacing", GAP, cyc - last_t);
            last_t = cyc;
            @(negedge clock_i);
        end
    endtask : take_word

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 6 * DIV) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 6 * DIV) begin
            fail_count++;
            $display("unexpected timeout waiting for idle");
            summarize();
        end
        repeat (2 * DIV) @(negedge clock_i);
        check_vec("line after cycle", 36'h0, {34'h0, serial_tx_o, busy_o});
    endtask : wait_idle

    // ====
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        send_request_i = 1'b0;
        {addr_level, addr_float, pay_level, pay_float, local_level, local_float} = '0;
        void'($urandom(74));
        repeat (16) @(posedge clock_i);
        check_vec("line in reset", 36'h0, {34'h0, serial_tx_o, busy_o});
        sys_rst_i <= 1'b0;
        // short request, float beats level, inputs changed after the snapshot
        al = 10'($urandom) | 10'h200;
        af = 10'($urandom) | 10'h200;
        dl = 8'($urandom) | 8'h81;
        df = (8'($urandom) | 8'h01) & 8'h7f;
        exp_w = expect_word({df, af}, {dl, al});
        pay_a = dl & ~df;
        drive();
        local_level <= al;
        local_float <= af;
        @(posedge clock_i);
        send_request_i <= 1'b1;
        repeat (6) @(negedge clock_i);
        check_vec("busy after request", 36'h1, {35'h0, busy_o});
        repeat (200) @(posedge clock_i);
        send_request_i <= 1'b0;
        {al, af, dl, df} = ~{al, af, dl, df};
        drive();
        take_word(exp_w, 1'b0);
        take_word(exp_w, 1'b1);
        take_word(exp_w, 1'b1);
        wait_idle();
        check_vec("decoder match", 36'h1, {35'h0, match});
        check_vec("decoder payload", {28'h0, pay_a}, {28'h0, payload_out});
        // held request, payload changed mid-cycle, decoder address differs
        {al, af, dl, df} = {4'($urandom), 32'($urandom)};
        exp_w = expect_word({df, af}, {dl, al});
        drive();
        local_level <= al;
        local_float <= af ^ 10'h001;
        @(posedge clock_i);
        send_request_i <= 1'b1;
        take_word(exp_w, 1'b0);
        {dl, df} = ~{dl, df};
        drive();
        take_word(exp_w, 1'b1);
        take_word(exp_w, 1'b1);
        exp_w = expect_word({df, af}, {dl, al});
        take_word(exp_w, 1'b1);
        @(posedge clock_i);
        send_request_i <= 1'b0;
        take_word(exp_w, 1'b1);
        take_word(exp_w, 1'b1);
        wait_idle();
        check_vec("decoder match", 36'h0, {35'h0, match});
        check_vec("decoder payload", {28'h0, pay_a}, {28'h0, payload_out});
        summarize();
    end
endmodule : testbench
`default_nettype wire
